// file: hw/cic_edge.sv
// rising-edge and change detector on synchronised levels
// assumes inputs already synchronised to mclk
`timescale 1ns/1ps
module cic_edge #(
  parameter int PORT_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  cic_sync_if.dst                sync,
  output logic                   timer_ovf_ev,
  output logic                   edge_pin_ev,
  output logic                   bus_coll_ev,
  output logic                   low_volt_ev,
  output logic [PORT_W-1:0]      pin_changed
);
  logic [2:0]        prim_reg;
  logic [3:0]        lvl_reg;
  logic [PORT_W-1:0] pins_reg;
  wire  [3:0]        lvl_now = {sync.low_volt, sync.bus_coll,
                                sync.edge_pin, sync.timer_ovf};

  // the synchroniser restarts from zero, so history primes over three
  // edges and a pin already high at reset does not fake a change;
  // a real change inside those edges is lost
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prim_reg <= '0;
      lvl_reg  <= '0;
      pins_reg <= '0;
    end else if (clk_en) begin
      prim_reg <= {prim_reg[1:0], 1'b1};
      lvl_reg  <= lvl_now;
      pins_reg <= sync.port_pins;
    end
  end

  wire       primed = prim_reg[2];
  wire [3:0] rise = lvl_now & ~lvl_reg & {4{primed}};
  assign timer_ovf_ev = rise[0];
  assign edge_pin_ev  = rise[1];
  assign bus_coll_ev  = rise[2];
  assign low_volt_ev  = rise[3];
  assign pin_changed  = (sync.port_pins ^ pins_reg) & {PORT_W{primed}};
endmodule : cic_edge

// file: hw/cic_pkg.sv
// package of constants for the core interrupt control block
// assumes an 8-bit register port and a single 100 MHz clock
package cic_pkg;
  localparam int          CIC_DATA_W          = 8;
  localparam int          CIC_ADDR_W          = 9;
  localparam int          CIC_PORT_W          = 8;
  // register offsets: the control register is mirrored in four banks
  localparam logic [8:0]  CIC_CTRL_BANK0_OFF  = 9'h00B;
  localparam logic [8:0]  CIC_CTRL_BANK1_OFF  = 9'h08B;
  localparam logic [8:0]  CIC_CTRL_BANK2_OFF  = 9'h10B;
  localparam logic [8:0]  CIC_CTRL_BANK3_OFF  = 9'h18B;
  localparam logic [8:0]  CIC_PERIPH2_OFF     = 9'h08D;
  localparam logic [8:0]  CIC_PINSEL_OFF      = 9'h096;
  localparam logic [8:0]  CIC_PSTAT_OFF       = 9'h0F0;
  localparam logic [8:0]  CIC_PMASK_OFF       = 9'h0F1;
  // control register field positions
  localparam int          CIC_GLOBAL_EN_BIT   = 7;
  localparam int          CIC_PERIPH_EN_BIT   = 6;
  localparam int          CIC_TIMER_EN_BIT    = 5;
  localparam int          CIC_EDGEIE_BIT      = 4;
  localparam int          CIC_PCIE_BIT        = 3;
  localparam int          CIC_T0F_BIT         = 2;
  localparam int          CIC_EDGEF_BIT       = 1;
  localparam int          CIC_PCF_BIT         = 0;
  // second peripheral enable register fields
  localparam int          CIC_LOWV_EN_BIT     = 7;
  localparam int          CIC_BUSCOL_EN_BIT   = 3;
  localparam logic [7:0]  CIC_PERIPH2_MASK    = 8'h88;
  // peripheral flag register fields (low voltage, bus collision)
  localparam int          CIC_LVDF_BIT        = 1;
  localparam int          CIC_BCLF_BIT        = 0;
  localparam logic [7:0]  CIC_PSTAT_MASK      = 8'h03;
  // reset values
  localparam logic [7:0]  CIC_CTRL_RST        = 8'h00;
  localparam logic [7:0]  CIC_PERIPH2_RST     = 8'h00;
  localparam logic [7:0]  CIC_PINSEL_RST      = 8'hF0;
  localparam logic [7:0]  CIC_PMASK_RST       = 8'h00;
endpackage : cic_pkg

// file: hw/cic_sync.sv
// two-stage synchronisers for every input from outside the clock
// assumes raw pin levels; all state freezes while clk_en is low
`timescale 1ns/1ps
module cic_sync #(
  parameter int PORT_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              timer_ovf_in,
  input  wire logic              edge_pin_in,
  input  wire logic              bus_coll_in,
  input  wire logic              low_volt_in,
  input  wire logic [PORT_W-1:0] port_pins_in,
  cic_sync_if.src                sync
);
  localparam int W = PORT_W + 4;

  logic [W-1:0] meta_reg;
  logic [W-1:0] stable_reg;
  wire  [W-1:0] raw_in = {port_pins_in, low_volt_in, bus_coll_in,
                          edge_pin_in, timer_ovf_in};

  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_reg   <= '0;
      stable_reg <= '0;
    end else if (clk_en) begin
      meta_reg   <= raw_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync.timer_ovf = stable_reg[0];
  assign sync.edge_pin  = stable_reg[1];
  assign sync.bus_coll  = stable_reg[2];
  assign sync.low_volt  = stable_reg[3];
  assign sync.port_pins = stable_reg[W-1:4];
endmodule : cic_sync

// file: hw/cic_sync_if.sv
// interface carrying synchronised event levels between modules
// assumes all signals are on the mclk domain
`timescale 1ns/1ps
interface cic_sync_if #(
  parameter int PORT_W = 8
);
  logic              timer_ovf;
  logic              edge_pin;
  logic              bus_coll;
  logic              low_volt;
  logic [PORT_W-1:0] port_pins;

  modport src (output timer_ovf, edge_pin, bus_coll, low_volt, port_pins);
  modport dst (input  timer_ovf, edge_pin, bus_coll, low_volt, port_pins);
endinterface : cic_sync_if

// file: hw/cic_top.sv
// core interrupt control: enables, flags, pin-change select, irq out
// assumes a simple register port on mclk and raw event pins
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps

module cic_top
  import cic_pkg::*;
#(
  parameter int PORT_W = cic_pkg::CIC_PORT_W
) (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire logic [cic_pkg::CIC_ADDR_W-1:0] reg_addr,
  input  wire logic [cic_pkg::CIC_DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [cic_pkg::CIC_DATA_W-1:0] reg_rdata,
  input  wire logic                          timer_ovf_pin,
  input  wire logic                          edge_pin,
  input  wire logic                          bus_coll_pin,
  input  wire logic                          low_volt_pin,
  input  wire logic [PORT_W-1:0]             port_pins,
  output logic                               irq
);
  import cic_pkg::*;

  // elaboration check: the pin select register is one byte wide
  if (PORT_W != CIC_DATA_W) begin : g_width_check
    $error("cic_top: PORT_W must equal the register width");
  end

  // registers
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] periph2_reg;
  logic [7:0] pinsel_reg;
  logic [7:0] pstat_reg;
  logic [7:0] pstat_next;
  logic [7:0] pmask_reg;
  logic [7:0] rdata_next;
  logic       irq_next;

  // synchronised events
  logic              timer_ovf_ev;
  logic              edge_pin_ev;
  logic              bus_coll_ev;
  logic              low_volt_ev;
  logic [PORT_W-1:0] pin_changed;

  cic_sync_if #(.PORT_W(PORT_W)) sync_bus ();

  cic_sync #(.PORT_W(PORT_W)) u_sync (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .clk_en       (clk_en),
    .timer_ovf_in (timer_ovf_pin),
    .edge_pin_in  (edge_pin),
    .bus_coll_in  (bus_coll_pin),
    .low_volt_in  (low_volt_pin),
    .port_pins_in (port_pins),
    .sync         (sync_bus)
  );

  cic_edge #(.PORT_W(PORT_W)) u_edge (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .clk_en       (clk_en),
    .sync         (sync_bus),
    .timer_ovf_ev (timer_ovf_ev),
    .edge_pin_ev  (edge_pin_ev),
    .bus_coll_ev  (bus_coll_ev),
    .low_volt_ev  (low_volt_ev),
    .pin_changed  (pin_changed)
  );

  // address match, reused for write and read decode
  function automatic logic is_ctrl(input logic [CIC_ADDR_W-1:0] a);
    is_ctrl = (a == CIC_CTRL_BANK0_OFF) || (a == CIC_CTRL_BANK1_OFF) ||
              (a == CIC_CTRL_BANK2_OFF) || (a == CIC_CTRL_BANK3_OFF);
  endfunction

  wire sel_ctrl    = is_ctrl(reg_addr);
  wire sel_periph2 = (reg_addr == CIC_PERIPH2_OFF);
  wire sel_pinsel  = (reg_addr == CIC_PINSEL_OFF);
  wire sel_pstat   = (reg_addr == CIC_PSTAT_OFF);
  wire sel_pmask   = (reg_addr == CIC_PMASK_OFF);

  wire wr_ctrl    = reg_wr && sel_ctrl;
  wire wr_periph2 = reg_wr && sel_periph2;
  wire wr_pinsel  = reg_wr && sel_pinsel;
  wire wr_pstat   = reg_wr && sel_pstat;
  wire wr_pmask   = reg_wr && sel_pmask;

  // only selected pins count as a port change
  wire port_change_ev = |(pin_changed & pinsel_reg);

  // hardware set events, one per flag bit of the control register
  wire [2:0] ctrl_set_ev = {timer_ovf_ev, edge_pin_ev, port_change_ev};

  // control register next value: write first, then events on top
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = reg_wdata;
    end
    // only software clears a flag; a set in the same cycle as
    // a clearing write wins so no event is lost
    if (ctrl_set_ev[2]) begin
      ctrl_next[CIC_T0F_BIT] = 1'b1;
    end
    if (ctrl_set_ev[1]) begin
      ctrl_next[CIC_EDGEF_BIT] = 1'b1;
    end
    if (ctrl_set_ev[0]) begin
      ctrl_next[CIC_PCF_BIT] = 1'b1;
    end
  end

  // peripheral status: write one to clear, set beats clear
  always_comb begin
    pstat_next = pstat_reg;
    if (wr_pstat) begin
      pstat_next = pstat_reg & ~reg_wdata;
    end
    if (low_volt_ev) begin
      pstat_next[CIC_LVDF_BIT] = 1'b1;
    end
    if (bus_coll_ev) begin
      pstat_next[CIC_BCLF_BIT] = 1'b1;
    end
    pstat_next = pstat_next & CIC_PSTAT_MASK;
  end

  wire t0_pend   = ctrl_reg[CIC_TIMER_EN_BIT] && ctrl_reg[CIC_T0F_BIT];
  wire edge_pend = ctrl_reg[CIC_EDGEIE_BIT] && ctrl_reg[CIC_EDGEF_BIT];
  // port change gated by its enable
  wire pc_pend   = ctrl_reg[CIC_PCIE_BIT]   && ctrl_reg[CIC_PCF_BIT];

  wire lvd_pend = periph2_reg[CIC_LOWV_EN_BIT] && pstat_reg[CIC_LVDF_BIT]
                  && pmask_reg[CIC_LVDF_BIT];
  wire bcl_pend = periph2_reg[CIC_BUSCOL_EN_BIT] && pstat_reg[CIC_BCLF_BIT]
                  && pmask_reg[CIC_BCLF_BIT];

  wire periph_pend = ctrl_reg[CIC_PERIPH_EN_BIT] && (lvd_pend || bcl_pend);

  assign irq_next = ctrl_reg[CIC_GLOBAL_EN_BIT] &&
                    (t0_pend || edge_pend || pc_pend || periph_pend);

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = '0;
    if (sel_ctrl) begin
      rdata_next = ctrl_reg;
    end else if (sel_periph2) begin
      rdata_next = periph2_reg & CIC_PERIPH2_MASK;
    end else if (sel_pinsel) begin
      rdata_next = pinsel_reg;
    end else if (sel_pstat) begin
      rdata_next = pstat_reg;
    end else if (sel_pmask) begin
      rdata_next = pmask_reg & CIC_PSTAT_MASK;
    end
  end

  // control and status registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg  <= CIC_CTRL_RST;
      pstat_reg <= '0;
    end else if (clk_en) begin
      ctrl_reg  <= ctrl_next;
      pstat_reg <= pstat_next;
    end
  end

  // software-only configuration registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      periph2_reg <= CIC_PERIPH2_RST;
      pinsel_reg  <= CIC_PINSEL_RST;
      pmask_reg   <= CIC_PMASK_RST;
    end else if (clk_en) begin
      if (wr_periph2) begin
        periph2_reg <= reg_wdata & CIC_PERIPH2_MASK;
      end
      if (wr_pinsel) begin
        pinsel_reg <= reg_wdata;
      end
      if (wr_pmask) begin
        pmask_reg <= reg_wdata & CIC_PSTAT_MASK;
      end
    end
  end

  // registered outputs; read data only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
      irq       <= 1'b0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_next : '0;
      irq       <= irq_next;
    end
  end
endmodule : cic_top

// file: tb/cic_top_assertions.sv
// checker for the interrupt control block, bound into cic_top
// assumes shadows track software-written fields and freeze with clk_en
`timescale 1ns/1ps
module cic_top_assertions
  import cic_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic                          mclk,
  input wire logic                          rst_n,
  input wire logic                          clk_en,
  input wire logic [cic_pkg::CIC_ADDR_W-1:0] reg_addr,
  input wire logic [cic_pkg::CIC_DATA_W-1:0] reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [cic_pkg::CIC_DATA_W-1:0] reg_rdata,
  input wire logic                          edge_pin,
  input wire logic                          irq
);
  logic [7:3] en_reg;
  logic [7:0] p2_reg;
  logic [7:0] sel_reg;
  // decode; all four control banks share the low seven address bits
  wire ctl_hit = reg_addr[6:0] == 7'h0B;
  wire p2_hit  = reg_addr == CIC_PERIPH2_OFF;
  wire sel_hit = reg_addr == CIC_PINSEL_OFF;
  wire known   = ctl_hit | p2_hit | sel_hit | reg_addr == CIC_PSTAT_OFF
               | reg_addr == CIC_PMASK_OFF;
  // enables change only by software, so they can be shadowed here
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      en_reg  <= 5'h00;
      p2_reg  <= CIC_PERIPH2_RST;
      sel_reg <= CIC_PINSEL_RST;
    end else if (clk_en && reg_wr) begin
      if (ctl_hit) en_reg <= reg_wdata[7:3];
      if (p2_hit) p2_reg <= reg_wdata & CIC_PERIPH2_MASK;
      if (sel_hit) sel_reg <= reg_wdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd)
    |-> reg_rdata == 8'h00) else $error("read data not idle");
  chk_ctrl_mirror: assert property ($past(reg_rd) && $past(ctl_hit)
    |-> reg_rdata[7:3] == $past(en_reg)) else $error("control readback");
  chk_p2_read: assert property ($past(reg_rd) && $past(p2_hit)
    |-> reg_rdata == $past(p2_reg)) else $error("enable two readback");
  chk_pinsel_read: assert property ($past(reg_rd) && $past(sel_hit)
    |-> reg_rdata == $past(sel_reg)) else $error("pin select readback");
  chk_unmapped_zero: assert property ($past(reg_rd) && !$past(known)
    |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_irq_global: assert property (irq |-> $past(en_reg[7]))
    else $error("irq without global enable");
  chk_irq_any_en: assert property (irq |-> $past(en_reg[6:3]) != 4'h0)
    else $error("irq without any enable");
  chk_irq_periph: assert property (irq && $past(en_reg[5:3]) == 3'h0
    |-> $past(en_reg[6])) else $error("peripheral irq without enable");
  chk_irq_sticky: assert property ($fell(irq)
    |-> $past(reg_wr) || $past(reg_wr, 2)) else $error("irq fell by itself");
  chk_edge_raises: assert property ($rose(edge_pin) && en_reg[7]
    && en_reg[4] |-> ##[2:6] irq) else $error("edge pin raised no irq");
  cover property ($rose(irq));
  cover property (reg_rd && p2_hit);
  cover property (reg_wr && reg_addr == CIC_CTRL_BANK3_OFF);
endmodule // cic_top_assertions

bind cic_top cic_top_assertions #(.PORT_W(PORT_W)) u_cic_top_assertions (
  .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .edge_pin(edge_pin), .irq(irq));

// file: tb/test_cic_top.sv
// self-checking bench for cic_top: registers, flags and irq
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
module test_cic_top;
  import cic_pkg::*;
  logic       mclk, rst_n, clk_en, reg_wr, reg_rd, irq;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, port_pins;
  logic [3:0] ev_pins;
  int         n_errors, n_tests, i;

  cic_top u_cic_top (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_ovf_pin(ev_pins[0]),
    .edge_pin(ev_pins[1]), .bus_coll_pin(ev_pins[2]),
    .low_volt_pin(ev_pins[3]), .port_pins(port_pins), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] seen, exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, "reg_rdata");
  endtask
  // irq is registered, so give it two edges after the last write
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, irq}, {7'h00, exp}, "irq");
  endtask
  // levels are held three cycles so the synchroniser cannot miss them
  task automatic ev(input logic [3:0] m);
    @(posedge mclk);
    ev_pins <= m;
    repeat (3) @(posedge mclk);
    ev_pins <= 4'h0;
    repeat (6) @(posedge mclk);
  endtask
  task automatic pins(input logic [7:0] p);
    @(posedge mclk);
    port_pins <= p;
    repeat (6) @(posedge mclk);
  endtask
  task automatic print_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // the sequence takes about 190 cycles; 20000 can only mean a hang
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, ev_pins} = 7'h00;
    {reg_addr, reg_wdata, port_pins} = 25'h0000000;
    clk_en   = 1'b1;
    n_errors = 0;
    n_tests  = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(CIC_CTRL_BANK0_OFF, 8'h00);
    rd(CIC_PINSEL_OFF, 8'hF0);
    rd(9'h1FF, 8'h00);
    wr(CIC_CTRL_BANK3_OFF, 8'h78);
    rd(CIC_CTRL_BANK1_OFF, 8'h78);
    rd(CIC_CTRL_BANK2_OFF, 8'h78);
    // flags set while global enable is off
    ev(4'b0011);
    irq_is(1'b0);
    pins(8'h01);
    rd(CIC_CTRL_BANK0_OFF, 8'h7E);
    pins(8'h81);
    rd(CIC_CTRL_BANK0_OFF, 8'h7F);
    wr(CIC_CTRL_BANK0_OFF, 8'hFF);
    irq_is(1'b1);
    wr(CIC_CTRL_BANK0_OFF, 8'h87);
    irq_is(1'b0);
    wr(CIC_CTRL_BANK0_OFF, 8'h90);
    ev(4'b0010);
    irq_is(1'b1);
    // port change needs its own enable too
    wr(CIC_CTRL_BANK0_OFF, 8'h80);
    pins(8'h01);
    rd(CIC_CTRL_BANK0_OFF, 8'h81);
    irq_is(1'b0);
    wr(CIC_CTRL_BANK0_OFF, 8'h89);
    irq_is(1'b1);
    wr(CIC_PMASK_OFF, 8'h03);
    wr(CIC_CTRL_BANK0_OFF, 8'hC0);
    for (i = 0; i < 2; i++) begin
      wr(CIC_PERIPH2_OFF, 8'h08 << (i * 4));
      ev(4'b0100 << i);
      rd(CIC_PSTAT_OFF, 8'h01 << i);
      irq_is(1'b1);
      wr(CIC_PSTAT_OFF, 8'h03);
      irq_is(1'b0);
    end
    wr(CIC_CTRL_BANK0_OFF, 8'h80);
    ev(4'b1000);
    irq_is(1'b0);
    wr(CIC_PERIPH2_OFF, 8'hFF);
    rd(CIC_PERIPH2_OFF, 8'h88);
    // timer overflow source with its enable
    wr(CIC_CTRL_BANK0_OFF, 8'hA0);
    ev(4'b0001);
    rd(CIC_CTRL_BANK0_OFF, 8'hA4);
    irq_is(1'b1);
    // a write while clk_en is low must not be taken
    clk_en <= 1'b0;
    wr(CIC_PINSEL_OFF, 8'h3C);
    @(posedge mclk);
    clk_en <= 1'b1;
    rd(CIC_PINSEL_OFF, 8'hF0);
    // mid-run reset with a selected pin held high: no fake change
    pins(8'h81);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(CIC_CTRL_BANK0_OFF, 8'h00);
    rd(CIC_PSTAT_OFF, 8'h00);
    irq_is(1'b0);
    print_verdict();
  end
endmodule // test_cic_top
